// ==== rtl/interlock_pkg.sv ====
package interlock_pkg;

    // Register addresses on the 16-bit register port
    localparam logic [15:0] ADDR_SOURCE_SELECT = 16'h4001;
    localparam logic [15:0] ADDR_PACK_VOLTAGE = 16'h405e;
    localparam logic [15:0] ADDR_STOP_TIMEOUT = 16'h40dd;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'h4100;
    localparam logic [15:0] ADDR_IRQ_CLEAR = 16'h4101;
    localparam logic [15:0] ADDR_IRQ_ENABLE = 16'h4102;
    localparam logic [15:0] ADDR_CONTROL = 16'h4103;
    localparam logic [15:0] ADDR_STATE = 16'h4104;

    // Values after reset
    localparam logic [1:0] RST_SOURCE_SELECT = 2'h0;
    localparam logic [15:0] RST_PACK_VOLTAGE = 16'h0133;
    localparam logic [6:0] RST_STOP_TIMEOUT = 7'h00;
    localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;

    // Setting ranges in raw codes
    localparam logic [15:0] PACK_VOLTAGE_MIN = 16'h0133;
    localparam logic [15:0] PACK_VOLTAGE_MAX = 16'h0266;
    localparam logic [15:0] STOP_TIMEOUT_MAX = 16'h0050;

    // Interrupt status bit positions
    localparam int IRQ_INTERLOCK_CHANGE = 0;
    localparam int IRQ_STOP_WINDOW = 1;
    localparam int IRQ_SHUTDOWN = 2;
    localparam int IRQ_WIDTH = 3;

    // Control register bit positions
    localparam int CTRL_FAULT_RESET = 0;

    // Timeout tick
    localparam longint CLK_HZ = 20000000;
    localparam longint TICK_MS = 100;
    localparam longint TICK_CYCLES = (CLK_HZ * TICK_MS) / 1000;

    typedef enum logic [1:0] {
        SRC_KEY_POWER = 2'b00,
        SRC_SINGLE_NO = 2'b01,
        SRC_NO_NC_PAIR = 2'b10,
        SRC_CAN_PDO = 2'b11
    } source_t;

    typedef enum logic [2:0] {
        ACT_NONE = 3'b000,
        ACT_WARNING = 3'b001,
        ACT_SHUTDOWN = 3'b010,
        ACT_WARN_THEN_SHUTDOWN = 3'b011,
        ACT_HOLD_THEN_SHUTDOWN = 3'b100
    } fault_action_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WARN_WAIT = 2'b01,
        ST_HOLD_WAIT = 2'b10,
        ST_SHUTDOWN = 2'b11
    } stop_state_t;

endpackage : interlock_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Pins in, filtered levels out
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] levelOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] level_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_ff <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_ff[i] == stage3_ff[i]) begin
                    level_ff[i] <= stage3_ff[i];
                end
            end
        end
    end

    assign levelOut = level_ff;
endmodule : pin_sync
`default_nettype wire

// ==== rtl/tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter longint CYCLES = 2000000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Control and tick
    input wire logic restart,
    output logic tick
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= '0;
        end else if (restart || count_ff == LAST) begin
            count_ff <= '0;
        end else begin
            count_ff <= count_ff + CW'(1);
        end
    end

    assign tick = (count_ff == LAST) && !restart;
endmodule : tick_gen
`default_nettype wire

// ==== rtl/interlock_fault_shutdown.sv ====
// Notes on behaviour
// - With source 0 the interlock follows the key power input.
// - With source 1 the interlock follows a normally-open switch on the first switch input.
// - With source 2 the interlock needs switch one closed and switch three open as a crossed pair.
// - With source 3 the interlock is the state the traction controller sends in its CAN message.
// - The stop timeout applies only to warning-then-shutdown and hold-then-shutdown faults.
// - The stop timeout bounds the time to stop, 0.0 to 8.0 s as codes 0 to 80.
// - A zero timeout shuts down at once with no warning and no hold phase.
// - When the timeout runs out before a stop, the fault output opens the contactor and frees the brake.
// - When the vehicle stops before the timeout ends, the shutdown happens at once.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module interlock_fault_shutdown #(
    parameter longint TICK_CYCLES = interlock_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // Vehicle pins
    input wire logic keyPowerIn,
    input wire logic switch1In,
    input wire logic switch3In,
    // Traction controller message
    input wire logic pdoValid,
    input wire logic pdoInterlock,
    // Steer fault reporting
    input wire logic faultEvent,
    input wire logic [2:0] faultAction,
    input wire logic vehicleStopped,
    // Outputs
    output logic interlock,
    output logic pairMismatch,
    output logic warningPhase,
    output logic holdPhase,
    output logic faultOutput,
    output logic contactorOpen,
    output logic electromagneticBrakeRelease,
    output logic irq
);
    // Synchronised pins
    logic keyPowerLvl;
    logic switch1Lvl;
    logic switch3Lvl;
    logic [2:0] pinLevels;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pinIn({switch3In, switch1In, keyPowerIn}),
        .levelOut(pinLevels)
    );

    assign keyPowerLvl = pinLevels[0];
    assign switch1Lvl = pinLevels[1];
    assign switch3Lvl = pinLevels[2];

    // Configuration registers
    interlock_pkg::source_t sourceSel_ff;
    logic [15:0] packVoltage_ff;
    logic [6:0] stopTimeout_ff;
    logic [interlock_pkg::IRQ_WIDTH-1:0] irqEnable_ff;
    logic [interlock_pkg::IRQ_WIDTH-1:0] irqStatus_ff;
    logic [interlock_pkg::IRQ_WIDTH-1:0] nxt_irqStatus;
    logic [interlock_pkg::IRQ_WIDTH-1:0] irqEvents;
    logic [interlock_pkg::IRQ_WIDTH-1:0] irqClear;
    logic faultResetReq;

    logic wrSource;
    logic wrVoltage;
    logic wrTimeout;
    logic wrIrqClear;
    logic wrIrqEnable;
    logic wrControl;

    assign wrSource = regWrite && (regAddr == interlock_pkg::ADDR_SOURCE_SELECT);
    assign wrVoltage = regWrite && (regAddr == interlock_pkg::ADDR_PACK_VOLTAGE);
    assign wrTimeout = regWrite && (regAddr == interlock_pkg::ADDR_STOP_TIMEOUT);
    assign wrIrqClear = regWrite && (regAddr == interlock_pkg::ADDR_IRQ_CLEAR);
    assign wrIrqEnable = regWrite && (regAddr == interlock_pkg::ADDR_IRQ_ENABLE);
    assign wrControl = regWrite && (regAddr == interlock_pkg::ADDR_CONTROL);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sourceSel_ff <= interlock_pkg::source_t'(interlock_pkg::RST_SOURCE_SELECT);
        end else if (wrSource) begin
            sourceSel_ff <= interlock_pkg::source_t'(regWrData[1:0]);
        end
    end

    // Stored as written; range upkeep is up to software
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            packVoltage_ff <= interlock_pkg::RST_PACK_VOLTAGE;
        end else if (wrVoltage) begin
            packVoltage_ff <= regWrData;
        end
    end

    // Codes above the top of the range saturate
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stopTimeout_ff <= interlock_pkg::RST_STOP_TIMEOUT;
        end else if (wrTimeout) begin
            if (regWrData > interlock_pkg::STOP_TIMEOUT_MAX) begin
                stopTimeout_ff <= interlock_pkg::STOP_TIMEOUT_MAX[6:0];
            end else begin
                stopTimeout_ff <= regWrData[6:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqEnable_ff <= interlock_pkg::RST_IRQ_ENABLE;
        end else if (wrIrqEnable) begin
            irqEnable_ff <= regWrData[interlock_pkg::IRQ_WIDTH-1:0];
        end
    end

    assign faultResetReq = wrControl && regWrData[interlock_pkg::CTRL_FAULT_RESET];

    // Interlock source selection
    logic pdoState_ff;
    logic nxt_interlock;
    logic nxt_mismatch;
    logic interlock_ff;
    logic mismatch_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pdoState_ff <= 1'b0;
        end else if (pdoValid) begin
            pdoState_ff <= pdoInterlock;
        end
    end

    always_comb begin
        nxt_interlock = 1'b0;
        nxt_mismatch = 1'b0;
        unique case (sourceSel_ff)
            interlock_pkg::SRC_KEY_POWER: begin
                nxt_interlock = keyPowerLvl;
            end
            interlock_pkg::SRC_SINGLE_NO: begin
                nxt_interlock = switch1Lvl;
            end
            interlock_pkg::SRC_NO_NC_PAIR: begin
                // Contacts that agree mean a broken switch or wire
                nxt_interlock = switch1Lvl && !switch3Lvl;
                nxt_mismatch = (switch1Lvl == switch3Lvl);
            end
            interlock_pkg::SRC_CAN_PDO: begin
                nxt_interlock = pdoState_ff;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            interlock_ff <= 1'b0;
            mismatch_ff <= 1'b0;
        end else begin
            interlock_ff <= nxt_interlock;
            mismatch_ff <= nxt_mismatch;
        end
    end

    // Fault stop sequence
    interlock_pkg::stop_state_t state_ff;
    interlock_pkg::stop_state_t nxt_state;
    logic [6:0] tickCount_ff;
    logic tick;
    logic delayedFault;
    logic immediateFault;
    logic startWindow;
    logic expired;

    // Fault detection restarts the tick so the first tick is a full 100 ms
    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick_gen (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .restart(startWindow),
        .tick(tick)
    );

    assign delayedFault = faultEvent &&
        ((faultAction == interlock_pkg::ACT_WARN_THEN_SHUTDOWN) ||
         (faultAction == interlock_pkg::ACT_HOLD_THEN_SHUTDOWN));
    assign immediateFault = faultEvent && (faultAction == interlock_pkg::ACT_SHUTDOWN);
    assign startWindow = (state_ff == interlock_pkg::ST_IDLE) && delayedFault &&
        (stopTimeout_ff != 7'h00);
    assign expired = (tickCount_ff >= stopTimeout_ff);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            interlock_pkg::ST_IDLE: begin
                if (immediateFault) begin
                    nxt_state = interlock_pkg::ST_SHUTDOWN;
                end else if (delayedFault && stopTimeout_ff == 7'h00) begin
                    nxt_state = interlock_pkg::ST_SHUTDOWN;
                end else if (delayedFault &&
                    faultAction == interlock_pkg::ACT_WARN_THEN_SHUTDOWN) begin
                    nxt_state = interlock_pkg::ST_WARN_WAIT;
                end else if (delayedFault) begin
                    nxt_state = interlock_pkg::ST_HOLD_WAIT;
                end
            end
            interlock_pkg::ST_WARN_WAIT,
            interlock_pkg::ST_HOLD_WAIT: begin
                if (vehicleStopped) begin
                    nxt_state = interlock_pkg::ST_SHUTDOWN;
                end else if (expired) begin
                    nxt_state = interlock_pkg::ST_SHUTDOWN;
                end else if (immediateFault) begin
                    nxt_state = interlock_pkg::ST_SHUTDOWN;
                end
            end
            interlock_pkg::ST_SHUTDOWN: begin
                if (faultResetReq) begin
                    nxt_state = interlock_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= interlock_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Count of 100 ms ticks since the fault was seen
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickCount_ff <= 7'h00;
        end else if (startWindow) begin
            tickCount_ff <= 7'h00;
        end else if (tick && !expired &&
            (state_ff == interlock_pkg::ST_WARN_WAIT ||
             state_ff == interlock_pkg::ST_HOLD_WAIT)) begin
            tickCount_ff <= tickCount_ff + 7'h01;
        end
    end

    // Registered outputs of the stop sequence
    logic warning_ff;
    logic hold_ff;
    logic fault_ff;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            warning_ff <= 1'b0;
            hold_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            warning_ff <= (nxt_state == interlock_pkg::ST_WARN_WAIT);
            hold_ff <= (nxt_state == interlock_pkg::ST_HOLD_WAIT);
            fault_ff <= (nxt_state == interlock_pkg::ST_SHUTDOWN);
        end
    end

    // Interrupt status, set wins over clear
    logic shutdownEntry;
    assign shutdownEntry = (nxt_state == interlock_pkg::ST_SHUTDOWN) &&
        (state_ff != interlock_pkg::ST_SHUTDOWN);

    assign irqEvents[interlock_pkg::IRQ_INTERLOCK_CHANGE] = (nxt_interlock != interlock_ff);
    assign irqEvents[interlock_pkg::IRQ_STOP_WINDOW] = startWindow;
    assign irqEvents[interlock_pkg::IRQ_SHUTDOWN] = shutdownEntry;
    assign irqClear = wrIrqClear ? regWrData[interlock_pkg::IRQ_WIDTH-1:0] : '0;

    always_comb begin
        nxt_irqStatus = (irqStatus_ff & ~irqClear) | irqEvents;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus_ff <= '0;
        end else begin
            irqStatus_ff <= nxt_irqStatus;
        end
    end

    // Read port, data in the cycle after the strobe
    logic [15:0] rdData_ff;
    logic [15:0] nxt_rdData;

    always_comb begin
        nxt_rdData = 16'h0000;
        unique case (regAddr)
            interlock_pkg::ADDR_SOURCE_SELECT: begin
                nxt_rdData = {14'h0000, sourceSel_ff};
            end
            interlock_pkg::ADDR_PACK_VOLTAGE: begin
                nxt_rdData = packVoltage_ff;
            end
            interlock_pkg::ADDR_STOP_TIMEOUT: begin
                nxt_rdData = {9'h000, stopTimeout_ff};
            end
            interlock_pkg::ADDR_IRQ_STATUS: begin
                nxt_rdData = {13'h0000, irqStatus_ff};
            end
            interlock_pkg::ADDR_IRQ_ENABLE: begin
                nxt_rdData = {13'h0000, irqEnable_ff};
            end
            interlock_pkg::ADDR_STATE: begin
                nxt_rdData = {tickCount_ff, 4'h0, state_ff, mismatch_ff, pdoState_ff, interlock_ff};
            end
            default: begin
                nxt_rdData = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_ff <= 16'h0000;
        end else if (regRead) begin
            rdData_ff <= nxt_rdData;
        end else begin
            rdData_ff <= 16'h0000;
        end
    end

    assign regRdData = rdData_ff;
    assign interlock = interlock_ff;
    assign pairMismatch = mismatch_ff;
    assign warningPhase = warning_ff;
    assign holdPhase = hold_ff;
    assign faultOutput = fault_ff;
    assign contactorOpen = fault_ff;
    assign electromagneticBrakeRelease = fault_ff;
    assign irq = |(irqStatus_ff & irqEnable_ff);
endmodule : interlock_fault_shutdown
`default_nettype wire

// ==== testbench/interlock_fault_shutdown_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module interlock_fault_shutdown_properties #(
    parameter longint TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData,
    // Inputs
    input wire logic keyPowerIn,
    input wire logic faultEvent,
    input wire logic [2:0] faultAction,
    input wire logic vehicleStopped,
    // Outputs
    input wire logic interlock,
    input wire logic warningPhase,
    input wire logic holdPhase,
    input wire logic faultOutput,
    input wire logic contactorOpen,
    input wire logic electromagneticBrakeRelease
);
    logic [6:0] tmo_ff;
    logic [1:0] src_ff;
    logic [15:0] waitCnt_ff;
    logic idle;
    logic inWait;
    logic longAct;
    assign idle = !(inWait || faultOutput);
    assign inWait = warningPhase || holdPhase;
    assign longAct = faultAction == 3'h3 || faultAction == 3'h4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Settings as written
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmo_ff <= 7'h00;
            src_ff <= 2'h0;
        end else if (regWrite && regAddr == interlock_pkg::ADDR_STOP_TIMEOUT) begin
            tmo_ff <= (regWrData > 16'h0050) ? 7'h50 : regWrData[6:0];
        end else if (regWrite && regAddr == interlock_pkg::ADDR_SOURCE_SELECT) begin
            src_ff <= regWrData[1:0];
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            waitCnt_ff <= 16'h0000;
        else
            waitCnt_ff <= inWait ? waitCnt_ff + 16'h0001 : 16'h0000;
    end
    contactor_follow_a: assert property ($rose(contactorOpen) |-> $past(faultEvent || inWait))
        else $error("contactor opened unasked");
    brake_follow_a: assert property ($fell(electromagneticBrakeRelease) |-> $past(regWrite))
        else $error("brake reapplied");
    read_idle_a: assert property (!$past(regRead) |-> regRdData == 16'h0000)
        else $error("stale read data");
    direct_shutdown_a: assert property (faultEvent && faultAction == 3'h2 |=> faultOutput)
        else $error("late shutdown");
    zero_timeout_a: assert property (idle && faultEvent && longAct && tmo_ff == 7'h00
        |=> faultOutput && !inWait) else $error("zero timeout waited");
    warn_start_a: assert property (idle && faultEvent && faultAction == 3'h3 && tmo_ff != 7'h00
        |=> warningPhase && !faultOutput) else $error("no warning");
    hold_start_a: assert property (idle && faultEvent && faultAction == 3'h4 && tmo_ff != 7'h00
        |=> holdPhase && !faultOutput) else $error("no hold");
    ignored_action_a: assert property (idle && faultEvent && faultAction < 3'h2
        |=> idle) else $error("ignored action acted");
    early_stop_a: assert property (inWait && vehicleStopped |-> ##[1:2] faultOutput)
        else $error("stop not honoured");
    wait_bound_a: assert property (inWait |-> waitCnt_ff <= tmo_ff * TICK_CYCLES + 4)
        else $error("wait too long");
    key_follow_a: assert property ((src_ff == 2'h0 && keyPowerIn) [*8] |-> interlock)
        else $error("key power ignored");
endmodule : interlock_fault_shutdown_properties
`default_nettype wire

// ==== testbench/traction_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module traction_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Bench control
    input wire logic sendPdo,
    input wire logic pdoState,
    input wire logic [15:0] stopAfter,
    // Device side
    input wire logic warningPhase,
    input wire logic holdPhase,
    output logic pdoValid,
    output logic pdoInterlock,
    output logic vehicleStopped
);
    logic [15:0] waitCnt_ff;
    // One-cycle message, garbage outside it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pdoValid <= 1'b0;
            pdoInterlock <= 1'b0;
        end else begin
            pdoValid <= sendPdo;
            pdoInterlock <= sendPdo ? pdoState : ~pdoInterlock;
        end
    end
    // Stop after stopAfter wait cycles, 0 never
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitCnt_ff <= 16'h0000;
            vehicleStopped <= 1'b0;
        end else if (warningPhase || holdPhase) begin
            waitCnt_ff <= waitCnt_ff + 16'h0001;
            vehicleStopped <= stopAfter != 16'h0000 && waitCnt_ff >= stopAfter;
        end else begin
            waitCnt_ff <= 16'h0000;
            vehicleStopped <= 1'b0;
        end
    end
endmodule : traction_model
`default_nettype wire

// ==== testbench/test_interlock_fault_shutdown.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_interlock_fault_shutdown;
    logic core_clk, sys_rst, regWrite, regRead, keyPowerIn, switch1In, switch3In, pdoValid, pdoInterlock;
    logic faultEvent, vehicleStopped, interlock, pairMismatch, warningPhase, holdPhase, faultOutput;
    logic contactorOpen, electromagneticBrakeRelease, irq, sendPdo, pdoState;
    logic [15:0] regAddr, regWrData, regRdData, stopAfter;
    logic [2:0] faultAction;
    int errors = 0, nCompared = 0, n;
    localparam logic [15:0] SRC = interlock_pkg::ADDR_SOURCE_SELECT, TMO = interlock_pkg::ADDR_STOP_TIMEOUT,
        VOLT = interlock_pkg::ADDR_PACK_VOLTAGE, ENA = interlock_pkg::ADDR_IRQ_ENABLE,
        STAT = interlock_pkg::ADDR_IRQ_STATUS, CLR = interlock_pkg::ADDR_IRQ_CLEAR;

    interlock_fault_shutdown #(.TICK_CYCLES(10)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .keyPowerIn(keyPowerIn), .switch1In(switch1In), .switch3In(switch3In),
        .pdoValid(pdoValid), .pdoInterlock(pdoInterlock), .faultEvent(faultEvent),
        .faultAction(faultAction), .vehicleStopped(vehicleStopped), .interlock(interlock),
        .pairMismatch(pairMismatch), .warningPhase(warningPhase), .holdPhase(holdPhase),
        .faultOutput(faultOutput), .contactorOpen(contactorOpen),
        .electromagneticBrakeRelease(electromagneticBrakeRelease), .irq(irq));
    traction_model partner (.core_clk(core_clk), .sys_rst(sys_rst), .sendPdo(sendPdo),
        .pdoState(pdoState), .stopAfter(stopAfter), .warningPhase(warningPhase),
        .holdPhase(holdPhase), .pdoValid(pdoValid), .pdoInterlock(pdoInterlock),
        .vehicleStopped(vehicleStopped));

    task automatic finish_test();
        if (errors == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chkBit(input logic got, input logic exp);
        chk16(16'(got), 16'(exp));
    endtask : chkBit
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chk16(regRdData, exp);
    endtask : rdChk
    task automatic pins(input logic k, input logic s1, input logic s3, input logic exp);
        @(posedge core_clk);
        keyPowerIn <= k;
        switch1In <= s1;
        switch3In <= s3;
        repeat (8) @(posedge core_clk);
        #1 chkBit(interlock, exp);
    endtask : pins
    task automatic pdo(input logic v);
        @(posedge core_clk);
        sendPdo <= 1'b1;
        pdoState <= v;
        @(posedge core_clk);
        sendPdo <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 chkBit(interlock, v);
    endtask : pdo
    task automatic fault(input logic [2:0] act);
        @(posedge core_clk);
        faultEvent <= 1'b1;
        faultAction <= act;
        @(posedge core_clk);
        faultEvent <= 1'b0;
        #1;
    endtask : fault
    task automatic waitOut(input int limit, output int cnt);
        cnt = 0;
        while (faultOutput !== 1'b1) begin
            @(posedge core_clk);
            #1 cnt++;
            if (cnt > limit) begin
                errors++;
                $display("unexpected at %0t: no shutdown", $time);
                finish_test();
            end
        end
    endtask : waitOut
    task automatic unshut();
        wr(interlock_pkg::ADDR_CONTROL, 16'h0001);
        wr(CLR, 16'h0007);
        repeat (2) @(posedge core_clk);
        #1 chkBit(faultOutput, 1'b0);
    endtask : unshut

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        $display("unexpected at %0t: run too long", $time);
        finish_test();
    end
    initial begin
        {regWrite, regRead, keyPowerIn, switch1In, switch3In, faultEvent, sendPdo, pdoState} = 8'h00;
        {regAddr, regWrData, stopAfter, faultAction} = 51'h0;
        sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdChk(SRC, 16'h0000);
        rdChk(VOLT, 16'h0133);
        rdChk(TMO, 16'h0000);
        rdChk(16'h4200, 16'h0000);
        wr(VOLT, 16'h0266);
        rdChk(VOLT, 16'h0266);
        wr(TMO, 16'h0064);
        rdChk(TMO, 16'h0050);
        pins(1'b1, 1'b0, 1'b0, 1'b1);
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        wr(SRC, 16'h0001);
        pins(1'b0, 1'b1, 1'b0, 1'b1);
        pins(1'b1, 1'b0, 1'b1, 1'b0);
        wr(SRC, 16'h0002);
        pins(1'b0, 1'b1, 1'b0, 1'b1);
        pins(1'b0, 1'b1, 1'b1, 1'b0);
        chkBit(pairMismatch, 1'b1);
        wr(SRC, 16'h0003);
        rdChk(SRC, 16'h0003);
        pdo(1'b1);
        pdo(1'b0);
        wr(ENA, 16'h0001);
        #1 chkBit(irq, 1'b1);
        wr(ENA, 16'h0000);
        #1 chkBit(irq, 1'b0);
        wr(CLR, 16'h0007);
        rdChk(STAT, 16'h0000);
        wr(ENA, 16'h0007);
        wr(TMO, 16'h0000);
        fault(3'h3);
        chkBit(faultOutput, 1'b1);
        chkBit(warningPhase, 1'b0);
        chkBit(contactorOpen, 1'b1);
        chkBit(electromagneticBrakeRelease, 1'b1);
        chkBit(irq, 1'b1);
        rdChk(interlock_pkg::ADDR_STATE, 16'h0018);
        unshut();
        fault(3'h4);
        chkBit(faultOutput, 1'b1);
        chkBit(holdPhase, 1'b0);
        unshut();
        wr(TMO, 16'h0003);
        fault(3'h0);
        fault(3'h1);
        chkBit(faultOutput | warningPhase | holdPhase, 1'b0);
        fault(3'h3);
        chkBit(warningPhase, 1'b1);
        waitOut(100, n);
        chkBit(n >= 28 && n <= 34, 1'b1);
        rdChk(STAT, 16'h0006);
        unshut();
        stopAfter <= 16'h0014;
        wr(TMO, 16'h0050);
        fault(3'h4);
        chkBit(holdPhase, 1'b1);
        waitOut(40, n);
        unshut();
        stopAfter <= 16'h0000;
        fault(3'h3);
        fault(3'h2);
        chkBit(faultOutput, 1'b1);
        unshut();
        finish_test();
    end
endmodule : test_interlock_fault_shutdown

bind interlock_fault_shutdown interlock_fault_shutdown_properties #(.TICK_CYCLES(TICK_CYCLES)) props (
    .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .keyPowerIn(keyPowerIn),
    .faultEvent(faultEvent), .faultAction(faultAction), .vehicleStopped(vehicleStopped),
    .interlock(interlock), .warningPhase(warningPhase), .holdPhase(holdPhase),
    .faultOutput(faultOutput), .contactorOpen(contactorOpen),
    .electromagneticBrakeRelease(electromagneticBrakeRelease));
`default_nettype wire
